/* File: shared/sample_ctl_pkg.sv */
// Constants and carriers for the sample-rate and auxiliary converter block.
// Assumes a 250 MHz system clock and a classic Wishbone register bus.
package sample_ctl_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned ODR_MIN_MHZ = 12_500;     // 12.5 Hz in mHz
    localparam int unsigned ODR_MAX_MHZ = 400_000;    // 400 Hz in mHz
    localparam int unsigned ODR_CODES   = 6;
    // Sample period in cycles for the slowest and fastest rate codes, rounded down
    localparam int unsigned CYC_12HZ5   = CLK_HZ / 1000 * 1000 / ODR_MIN_MHZ * 1000;
    localparam int unsigned CYC_400HZ   = CLK_HZ / (ODR_MAX_MHZ / 1000);

    // ************************************************************
    // Register map (byte offsets)
    // ************************************************************
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] STATUS_OFF  = 8'h04;
    localparam logic [7:0] ACCEL_OFF   = 8'h08;
    localparam logic [7:0] TEMP_OFF    = 8'h0c;
    localparam logic [7:0] AUX_OFF     = 8'h10;
    localparam logic [7:0] SAMPLES_OFF = 8'h14;

    // Control fields
    localparam int unsigned MEAS_BIT   = 0;
    localparam int unsigned ODR_LSB    = 1;      // 3 bits
    localparam int unsigned BW_BIT     = 4;
    localparam int unsigned NOISE_LSB  = 5;      // 2 bits
    localparam int unsigned AUX_EN_BIT = 7;
    localparam int unsigned TFIFO_BIT  = 8;
    localparam int unsigned EXT_BIT    = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0006; // 100 Hz, quarter band, standby

    localparam int unsigned SAMPLE_W = 12;

    typedef enum logic [1:0] {
        NOISE_NORMAL = 2'h0,
        NOISE_LOW    = 2'h1,
        NOISE_ULTRA  = 2'h2
    } noise_mode_e;

    typedef enum logic [1:0] {
        ST_STANDBY = 2'b00,
        ST_MEASURE = 2'b01,
        ST_CAPTURE = 2'b11
    } run_state_e;

    typedef struct packed {
        logic        measure;
        logic [2:0]  odr;
        logic        filter_bandwidth_select;
        noise_mode_e noise;
        logic        aux_en;
        logic        temp_to_fifo;
        logic        ext_trigger;
    } ctrl_s;

    typedef struct packed {
        logic                valid;
        logic                is_temp;
        logic [SAMPLE_W-1:0] data;
    } fifo_word_s;

    typedef struct packed {
        logic [SAMPLE_W-1:0] accel;
        logic [SAMPLE_W-1:0] temp;
        logic [SAMPLE_W-1:0] aux;
    } sensor_s;

endpackage

/* File: testbench/frontend_model.sv */
// Front end model: converter values and the external trigger pin.
// Assumes the bench pulses fire for one cycle to request a sample.
`timescale 1ns/1ps
module frontend_model
    import sample_ctl_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               fire,
    output sample_ctl_pkg::sensor_s sens_in,
    output logic                    ext_trigger_pin
);
    // ************************************************************
    // Values and trigger
    // ************************************************************
    logic [11:0] base_reg;
    logic [2:0]  pulse_reg;
    // New values per request, so a stale capture shows up
    always_ff @(posedge clk) begin
        if (rst) begin
            base_reg <= 12'h7f0;
        end else if (fire) begin
            base_reg <= base_reg + 12'h3a5;
        end
    end
    // Held four cycles so the synchroniser cannot miss it
    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_reg <= 3'h0;
        end else if (fire) begin
            pulse_reg <= 3'h4;
        end else if (pulse_reg != 3'h0) begin
            pulse_reg <= pulse_reg - 3'h1;
        end
    end
    assign ext_trigger_pin = (pulse_reg != 3'h0);
    assign sens_in = '{accel: base_reg, temp: ~base_reg, aux: base_reg ^ 12'h800};
endmodule

/* File: testbench/test_sample_ctl.sv */
// Self-checking bench for the sample control block.
// Assumes externally triggered sampling; the internal timer is too slow here.
`timescale 1ns/1ps
module test_sample_ctl;
    import sample_ctl_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        clk, rst, fire, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        ext_trigger_pin, sample_strobe, aux_power_on;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [1:0]  filter_divider;
    noise_mode_e noise_mode;
    fifo_word_s  fifo_out;
    sensor_s     sens_in, snap;
    int          fails = 0;
    int          n_checks = 0;
    localparam logic [31:0] CFG = 32'h0000_0397;
    sample_ctl sample_ctl_inst (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_trigger_pin(ext_trigger_pin), .sens_in(sens_in), .sample_strobe(sample_strobe),
        .aux_power_on(aux_power_on), .filter_divider(filter_divider),
        .noise_mode(noise_mode), .fifo_out(fifo_out));
    frontend_model frontend_model_inst (.clk(clk), .rst(rst), .fire(fire),
        .sens_in(sens_in), .ext_trigger_pin(ext_trigger_pin));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hf;
        wb_dat_i <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Fires one trigger; seen tells whether a sample strobe followed
    task automatic trigger(output logic seen);
        seen = 1'b0;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        for (int i = 0; i < 30 && !seen; i++) begin
            @(posedge clk);
            seen = (sample_strobe === 1'b1);
        end
        snap = sens_in;
    endtask
    // Aux words must never appear on the FIFO side
    always @(posedge clk) begin
        if (fifo_out.valid === 1'b1) chk({31'h0, fifo_out.is_temp}, 32'h1);
    end
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        wb(1'b0, CTRL_OFF, 32'h0);
        chk(rd, CTRL_RESET);
        wb(1'b0, STATUS_OFF, 32'h0);
        chk(rd, 32'h0);
        chk({30'h0, filter_divider}, 32'h2);
        chk({31'h0, aux_power_on}, 32'h0);
        wb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 3; m++) begin
            wb(1'b1, CTRL_OFF, CFG | (m << NOISE_LSB));
            repeat (2) @(posedge clk);
            chk({30'h0, noise_mode}, m);
            chk({30'h0, filter_divider}, 32'h1);
            chk({31'h0, aux_power_on}, 32'h1);
            wb(1'b0, CTRL_OFF, 32'h0);
            chk(rd, CFG | (m << NOISE_LSB));
        end
        wb(1'b0, STATUS_OFF, 32'h0);
        chk(rd & 32'h3, 32'h1);
        $display("test modes done");
    endtask
    task automatic t_sample();
        logic        seen;
        logic [15:0] cnt;
        for (int k = 0; k < 2; k++) begin
            wb(1'b0, SAMPLES_OFF, 32'h0);
            cnt = rd[15:0];
            trigger(seen);
            chk({31'h0, seen}, 32'h1);
            chk({18'h0, fifo_out}, {18'h0, 2'b11, snap.temp});
            wb(1'b0, TEMP_OFF, 32'h0);
            chk(rd, {{20{snap.temp[11]}}, snap.temp});
            wb(1'b0, AUX_OFF, 32'h0);
            chk(rd, {{20{snap.aux[11]}}, snap.aux});
            wb(1'b0, SAMPLES_OFF, 32'h0);
            chk({16'h0, rd[15:0]}, {16'h0, cnt + 16'h1});
        end
        $display("test sample done");
    endtask
    task automatic t_aux_off();
        logic        seen;
        logic [31:0] old_aux;
        wb(1'b0, AUX_OFF, 32'h0);
        old_aux = rd;
        wb(1'b1, CTRL_OFF, CFG & ~(32'h1 << AUX_EN_BIT) & ~(32'h1 << TFIFO_BIT));
        repeat (2) @(posedge clk);
        chk({31'h0, aux_power_on}, 32'h0);
        trigger(seen);
        chk({31'h0, seen}, 32'h1);
        chk({31'h0, fifo_out.valid}, 32'h0);
        wb(1'b0, AUX_OFF, 32'h0);
        chk(rd, old_aux);
        wb(1'b0, TEMP_OFF, 32'h0);
        chk(rd, {{20{snap.temp[11]}}, snap.temp});
        $display("test aux off done");
    endtask
    task automatic t_standby();
        logic        seen;
        logic [31:0] old_temp;
        logic [31:0] old_cnt;
        wb(1'b0, TEMP_OFF, 32'h0);
        old_temp = rd;
        wb(1'b1, CTRL_OFF, CFG & ~32'h1);
        trigger(seen);
        chk({31'h0, seen}, 32'h0);
        wb(1'b0, TEMP_OFF, 32'h0);
        chk(rd, old_temp);
        wb(1'b0, STATUS_OFF, 32'h0);
        chk(rd, 32'h0);
        // Internal timer: the pin must not pace, and no sample comes this early
        wb(1'b0, SAMPLES_OFF, 32'h0);
        old_cnt = rd;
        wb(1'b1, CTRL_OFF, CFG & ~(32'h1 << EXT_BIT));
        trigger(seen);
        chk({31'h0, seen}, 32'h0);
        wb(1'b0, SAMPLES_OFF, 32'h0);
        chk(rd, old_cnt);
        wb(1'b0, STATUS_OFF, 32'h0);
        chk(rd, 32'h1);
        $display("test standby done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(4 * 20000);
        fails++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        fire = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_sample();
        t_aux_off();
        t_standby();
        summarize();
    end
endmodule

/* File: verilog/sample_ctl.sv */
// Sample pacing, filter/noise setup and auxiliary converter readout.
// Assumes converted values arrive on sens_in; trigger pin is asynchronous.
//
// Operation
// - Rate selectable from 12.5 to 400 Hz
// - Filter pole at quarter or half rate
// - Reset selects quarter-rate filter bandwidth
// - Converter samples only at selected rate, or on trigger pin rising edges when ext_trigger is set
// - Normal, low and ultralow noise modes
// - Auxiliary converter can be powered down
// - Auxiliary result 12-bit twos complement, readable
// - Auxiliary captured with accel and temperature
// - Internal timer limits auxiliary to 400/s
// - Auxiliary results never enter the FIFO
// - Option stores temperature samples in FIFO
// - Temperature updates with other samples
// - Temperature readings are 12 bits
// - Standby at reset, sampling suspended, data kept
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module sample_ctl
    import sample_ctl_pkg::*;
(
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             wb_cyc_i,
    input  wire logic                             wb_stb_i,
    input  wire logic                             wb_we_i,
    input  wire logic [7:0]                       wb_adr_i,
    input  wire logic [3:0]                       wb_sel_i,
    input  wire logic [31:0]                      wb_dat_i,
    output logic      [31:0]                      wb_dat_o,
    output logic                                  wb_ack_o,
    input  wire logic                             ext_trigger_pin,
    input  wire sample_ctl_pkg::sensor_s          sens_in,
    output logic                                  sample_strobe,
    output logic                                  aux_power_on,
    output logic      [1:0]                       filter_divider,
    output sample_ctl_pkg::noise_mode_e           noise_mode,
    output sample_ctl_pkg::fifo_word_s            fifo_out
);
    import sample_ctl_pkg::*;

    // ************************************************************
    // Control register and bus slave
    // ************************************************************
    ctrl_s       ctrl_reg;
    sensor_s     data_reg;
    logic [15:0] count_reg;
    logic        wb_req;
    logic        ctrl_wr;
    logic [31:0] rd_next;
    run_state_e  state_reg;

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ctrl_wr = wb_req && wb_we_i && wb_adr_i == CTRL_OFF;

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Low byte holds measure/odr/bw/noise/aux, byte 1 the FIFO and trigger bits
    always_ff @(posedge clk) begin
        if (rst) begin
            // Field by field: the struct packs its fields in another order than the register
            ctrl_reg.measure                 <= CTRL_RESET[MEAS_BIT];
            ctrl_reg.odr                     <= CTRL_RESET[ODR_LSB +: 3];
            ctrl_reg.filter_bandwidth_select <= CTRL_RESET[BW_BIT];
            ctrl_reg.noise                   <= noise_mode_e'(CTRL_RESET[NOISE_LSB +: 2]);
            ctrl_reg.aux_en                  <= CTRL_RESET[AUX_EN_BIT];
            ctrl_reg.temp_to_fifo            <= CTRL_RESET[TFIFO_BIT];
            ctrl_reg.ext_trigger             <= CTRL_RESET[EXT_BIT];
        end else if (ctrl_wr) begin
            if (wb_sel_i[0]) begin
                ctrl_reg.measure                 <= wb_dat_i[MEAS_BIT];
                ctrl_reg.odr                     <= wb_dat_i[ODR_LSB +: 3];
                ctrl_reg.filter_bandwidth_select <= wb_dat_i[BW_BIT];
                ctrl_reg.noise                   <= noise_mode_e'(wb_dat_i[NOISE_LSB +: 2]);
                ctrl_reg.aux_en                  <= wb_dat_i[AUX_EN_BIT];
            end
            if (wb_sel_i[1]) begin
                ctrl_reg.temp_to_fifo <= wb_dat_i[TFIFO_BIT];
                ctrl_reg.ext_trigger  <= wb_dat_i[EXT_BIT];
            end
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        case (wb_adr_i)
            CTRL_OFF: begin
                rd_next[MEAS_BIT]         = ctrl_reg.measure;
                rd_next[ODR_LSB +: 3]     = ctrl_reg.odr;
                rd_next[BW_BIT]           = ctrl_reg.filter_bandwidth_select;
                rd_next[NOISE_LSB +: 2]   = ctrl_reg.noise;
                rd_next[AUX_EN_BIT]       = ctrl_reg.aux_en;
                rd_next[TFIFO_BIT]        = ctrl_reg.temp_to_fifo;
                rd_next[EXT_BIT]          = ctrl_reg.ext_trigger;
            end
            STATUS_OFF:  rd_next[1:0] = state_reg;
            ACCEL_OFF:   rd_next = {{20{data_reg.accel[11]}}, data_reg.accel};
            TEMP_OFF:    rd_next = {{20{data_reg.temp[11]}}, data_reg.temp};
            AUX_OFF:     rd_next = {{20{data_reg.aux[11]}}, data_reg.aux};
            SAMPLES_OFF: rd_next[15:0] = count_reg;
            default:     rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= rd_next;
        end
    end

    // ************************************************************
    // Rate timer and trigger synchroniser
    // ************************************************************
    // Rate codes 0..5: 12.5, 25, 50, 100, 200, 400 Hz; 6 and 7 act as 400 Hz
    logic [31:0] period;
    logic [31:0] tick_cnt_reg;
    logic [2:0]  trig_sync_reg;
    logic        trig_level_reg;
    logic        trig_event;
    logic        tick;

    always_comb begin
        if (ctrl_reg.odr < 3'(ODR_CODES)) begin
            period = CYC_12HZ5 >> ctrl_reg.odr;
        end else begin
            period = CYC_400HZ;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            trig_sync_reg  <= 3'h0;
            trig_level_reg <= 1'b0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], ext_trigger_pin};
            if (trig_sync_reg[2] == trig_sync_reg[1]) begin
                trig_level_reg <= trig_sync_reg[2];
            end
        end
    end

    assign trig_event = trig_sync_reg[2] == trig_sync_reg[1]
                        && trig_sync_reg[2] && !trig_level_reg;

    // Internal pacing never beats the 400 Hz period; external may go faster
    always_ff @(posedge clk) begin
        if (rst || state_reg == ST_STANDBY) begin
            tick_cnt_reg <= 32'h0;
        end else if (tick_cnt_reg + 32'h1 >= period) begin
            tick_cnt_reg <= 32'h0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h1;
        end
    end

    assign tick = ctrl_reg.ext_trigger ? trig_event
                                       : (tick_cnt_reg + 32'h1 >= period);

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ST_STANDBY;
        end else begin
            case (state_reg)
                ST_STANDBY: if (ctrl_reg.measure) state_reg <= ST_MEASURE;
                ST_MEASURE: begin
                    if (!ctrl_reg.measure) begin
                        state_reg <= ST_STANDBY;
                    end else if (tick) begin
                        state_reg <= ST_CAPTURE;
                    end
                end
                ST_CAPTURE: state_reg <= ctrl_reg.measure ? ST_MEASURE : ST_STANDBY;
                default:    state_reg <= ST_STANDBY;
            endcase
        end
    end

    // One capture event latches accel, temp and, if aux_en, aux together; standby keeps old data
    always_ff @(posedge clk) begin
        if (rst) begin
            data_reg      <= '0;
            count_reg     <= 16'h0;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= state_reg == ST_CAPTURE;
            if (state_reg == ST_CAPTURE) begin
                data_reg.accel <= sens_in.accel;
                data_reg.temp  <= sens_in.temp;
                if (ctrl_reg.aux_en) begin
                    data_reg.aux <= sens_in.aux;
                end
                count_reg <= count_reg + 16'h1;
            end
        end
    end

    // Only temperature may join the FIFO stream; the aux path has no route here
    always_ff @(posedge clk) begin
        if (rst) begin
            fifo_out <= '0;
        end else begin
            fifo_out.valid   <= state_reg == ST_CAPTURE && ctrl_reg.temp_to_fifo;
            fifo_out.is_temp <= 1'b1;
            fifo_out.data    <= sens_in.temp;
        end
    end

    // ************************************************************
    // Analog setup outputs
    // ************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            aux_power_on   <= 1'b0;
            filter_divider <= 2'h2;
            noise_mode     <= NOISE_NORMAL;
        end else begin
            aux_power_on   <= ctrl_reg.aux_en && state_reg != ST_STANDBY;
            filter_divider <= ctrl_reg.filter_bandwidth_select ? 2'h1 : 2'h2;
            noise_mode     <= ctrl_reg.noise;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    bw_reset_a: assert property (@(posedge clk) $fell(rst) |-> filter_divider == 2'h2)
        else $error("filter not quarter after reset");
    bw_map_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_reg.filter_bandwidth_select |=> filter_divider == 2'h1)
        else $error("half band not applied");
    quarter_map_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_reg.filter_bandwidth_select |=> filter_divider == 2'h2)
        else $error("quarter band not applied");
    standby_hold_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_STANDBY |=> $stable(data_reg) && !fifo_out.valid)
        else $error("data changed in standby");
    standby_stay_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_STANDBY && !ctrl_reg.measure |=> state_reg == ST_STANDBY)
        else $error("left standby without measure");
    capture_strobe_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_CAPTURE |=> sample_strobe)
        else $error("capture without strobe");
    strobe_pulse_a: assert property (@(posedge clk) disable iff (rst)
        sample_strobe |=> !sample_strobe)
        else $error("strobe longer than one cycle");
    count_step_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_CAPTURE |=> count_reg == $past(count_reg) + 16'h1)
        else $error("sample count not advanced");
    capture_data_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_CAPTURE |=> data_reg.temp == $past(sens_in.temp)
        && data_reg.accel == $past(sens_in.accel))
        else $error("temperature not captured with accel");
    aux_off_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_reg.aux_en && state_reg == ST_CAPTURE |=> $stable(data_reg.aux))
        else $error("aux updated while off");
    aux_power_a: assert property (@(posedge clk) disable iff (rst)
        state_reg == ST_STANDBY |=> !aux_power_on)
        else $error("aux powered in standby");
    aux_follow_a: assert property (@(posedge clk) disable iff (rst)
        ctrl_reg.aux_en && state_reg == ST_MEASURE |=> aux_power_on)
        else $error("aux not powered while measuring");
    temp_fifo_a: assert property (@(posedge clk) disable iff (rst)
        fifo_out.valid |-> $past(ctrl_reg.temp_to_fifo) && sample_strobe)
        else $error("fifo write without option");
    fifo_temp_a: assert property (@(posedge clk) disable iff (rst)
        fifo_out.valid |-> fifo_out.is_temp && fifo_out.data == data_reg.temp)
        else $error("fifo word is not temperature");
    noise_map_a: assert property (@(posedge clk) disable iff (rst)
        ##1 noise_mode == $past(ctrl_reg.noise))
        else $error("noise mode not followed");
    // Internal pacing needs at least 625,000 cycles a sample, so only long runs reach this one
    rate_limit_a: assert property (@(posedge clk) disable iff (rst)
        !ctrl_reg.ext_trigger && state_reg == ST_CAPTURE
        |=> state_reg != ST_CAPTURE [*2])
        else $error("internal capture too fast");
    ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (@(posedge clk) disable iff (rst)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");

    capture_c: cover property (@(posedge clk) disable iff (rst) sample_strobe);
    ext_c:     cover property (@(posedge clk) disable iff (rst)
        ctrl_reg.ext_trigger && state_reg == ST_CAPTURE);
    tfifo_c:   cover property (@(posedge clk) disable iff (rst) fifo_out.valid);
    stop_c:    cover property (@(posedge clk) disable iff (rst)
        state_reg == ST_MEASURE ##1 state_reg == ST_STANDBY);
    internal_c: cover property (@(posedge clk) disable iff (rst)
        state_reg == ST_MEASURE && !ctrl_reg.ext_trigger);

endmodule
